/* File: bench/conv_output_ctrl_chk.sv */
// Assertion checker for the converter output block
`timescale 1ns/1ns
module conv_output_ctrl_chk (
	input wire        clk_sys,
	input wire        rst,
	input wire        use_pins,
	input wire        reg_stby,
	input wire        reg_pdn_obuf,
	input wire        reg_coarse_gain,
	input wire [1:0]  reg_lvds_current,
	input wire        coarse_gain_ff,
	input wire [2:0]  fine_gain_ff,
	input wire [1:0]  lvds_current_ff,
	input wire [1:0]  power_mode_ff,
	input wire        core_on_ff,
	input wire        ref_on_ff,
	input wire        clock_stopped_ff,
	input wire        data_valid_ff,
	input wire [13:0] sample_bit_oe_n,
	input wire [6:0]  pair_bit_oe_n,
	input wire        output_clock_oe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_gain_rst;
		$past(rst) |-> !coarse_gain_ff && fine_gain_ff == 3'h0;
	endproperty
	property p_fine;
		fine_gain_ff <= 3'h6;
	endproperty
	property p_coarse;
		!$past(rst) |-> coarse_gain_ff == $past(reg_coarse_gain);
	endproperty
	property p_cur;
		!$past(rst) |-> lvds_current_ff == $past(reg_lvds_current);
	endproperty
	property p_mode;
		(!use_pins && $stable({reg_pdn_obuf, reg_stby}))[*3]
			|-> power_mode_ff == {reg_pdn_obuf, reg_stby};
	endproperty
	property p_global;
		(power_mode_ff == 2'h3)[*2] |-> &sample_bit_oe_n && &pair_bit_oe_n
			&& output_clock_oe_n && !ref_on_ff && !core_on_ff;
	endproperty
	property p_stby;
		(power_mode_ff == 2'h1)[*2] |-> !core_on_ff && ref_on_ff;
	endproperty
	property p_obuf;
		(power_mode_ff == 2'h2)[*2] |-> &sample_bit_oe_n && output_clock_oe_n && core_on_ff;
	endproperty
	property p_stop;
		clock_stopped_ff [*2] |-> !data_valid_ff;
	endproperty
	a_gain_rst: assert property (p_gain_rst) else $error("gain not zero after reset");
	a_fine: assert property (p_fine) else $error("fine gain out of range");
	a_coarse: assert property (p_coarse) else $error("coarse gain not taken");
	a_cur: assert property (p_cur) else $error("driver current not taken");
	a_mode: assert property (p_mode) else $error("power mode wrong");
	a_global: assert property (p_global) else $error("global power down wrong");
	a_stby: assert property (p_stby) else $error("standby wrong");
	a_obuf: assert property (p_obuf) else $error("output disable wrong");
	a_stop: assert property (p_stop) else $error("valid while clock stopped");
	c_global: cover property (power_mode_ff == 2'h3);
	c_stop: cover property (clock_stopped_ff);
	c_valid: cover property ($rose(data_valid_ff));
endmodule // conv_output_ctrl_chk

/* File: bench/conv_output_ctrl_tb.sv */
// Self-checking bench for the converter output block
`timescale 1ns/1ns
module conv_output_ctrl_tb;
	reg         clk_sys, rst, sample_clk, sc_run, chk_on, use_pins, pin_pd, pin_buf;
	reg         pin_diff, pin_twos, reg_stby, reg_pdn_obuf, reg_diff, reg_twos, reg_ext_ref;
	reg         reg_coarse_gain, reg_current_double, dly_sel;
	reg  [2:0]  reg_fine_gain;
	reg  [3:0]  reg_drive_strength;
	reg  [1:0]  reg_lvds_current;
	reg  [13:0] cnt, flip, prev;
	reg  [19:0] rows [0:9];
	integer     n_errors, n_checks, seen, i;
	wire        ext_ref_sel_ff, coarse_gain_ff, current_double_ff, core_on_ff, ref_on_ff;
	wire        clock_stopped_ff, data_valid_ff, output_clock, output_clock_true;
	wire        output_clock_oe_n, output_clock_delayed;
	wire [2:0]  fine_gain_ff;
	wire [3:0]  drive_strength_ff;
	wire [1:0]  lvds_current_ff, power_mode_ff;
	wire [13:0] sample_bit, sample_bit_oe_n, se_word, ddr_word, w;
	wire [6:0]  pair_bit, pair_bit_oe_n;
	wire        oclk = reg_diff ? output_clock_true : output_clock;
	wire [10:0] cfg = {fine_gain_ff, drive_strength_ff, coarse_gain_ff, ext_ref_sel_ff,
		current_double_ff, output_clock_delayed};
	assign w = (reg_diff ? ddr_word : se_word) ^ flip;

	conv_output_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .sample_clk(sample_clk),
		.core_data(cnt), .use_pins(use_pins), .pin_pd(pin_pd), .pin_buf(pin_buf),
		.pin_diff(pin_diff), .pin_twos(pin_twos), .reg_stby(reg_stby),
		.reg_pdn_obuf(reg_pdn_obuf), .reg_diff(reg_diff), .reg_twos(reg_twos),
		.reg_ext_ref(reg_ext_ref), .reg_coarse_gain(reg_coarse_gain),
		.reg_fine_gain(reg_fine_gain), .output_clock_delay_select(dly_sel),
		.reg_drive_strength(reg_drive_strength), .reg_lvds_current(reg_lvds_current),
		.reg_current_double(reg_current_double), .ext_ref_sel_ff(ext_ref_sel_ff),
		.coarse_gain_ff(coarse_gain_ff), .fine_gain_ff(fine_gain_ff),
		.drive_strength_ff(drive_strength_ff), .lvds_current_ff(lvds_current_ff),
		.current_double_ff(current_double_ff), .power_mode_ff(power_mode_ff),
		.core_on_ff(core_on_ff), .ref_on_ff(ref_on_ff), .clock_stopped_ff(clock_stopped_ff),
		.data_valid_ff(data_valid_ff), .sample_bit(sample_bit),
		.sample_bit_oe_n(sample_bit_oe_n), .pair_bit(pair_bit), .pair_bit_oe_n(pair_bit_oe_n),
		.output_clock(output_clock), .output_clock_true(output_clock_true),
		.output_clock_oe_n(output_clock_oe_n), .output_clock_delayed(output_clock_delayed));

	sample_receiver i_rx (.output_clock(output_clock), .output_clock_true(output_clock_true),
		.sample_pins(sample_bit ^ sample_bit_oe_n), .pair_pins(pair_bit ^ pair_bit_oe_n),
		.se_word(se_word), .ddr_word(ddr_word));

	task check(input [13:0] seen_v, input [13:0] exp_v);
		begin
			n_checks = n_checks + 1;
			if (seen_v !== exp_v) begin
				n_errors = n_errors + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
			end
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task wait_valid(input integer lim);
		integer k;
		begin
			for (k = 0; k < lim && data_valid_ff !== 1'b1; k = k + 1) @(negedge clk_sys);
			check(data_valid_ff, 1'b1);
			if (data_valid_ff !== 1'b1) report_and_stop;
		end
	endtask

	task stream;
		integer k;
		begin
			seen = 0;
			chk_on = 1;
			for (k = 0; k < 3000 && seen < 8; k = k + 1) @(negedge clk_sys);
			chk_on = 0;
			check(seen > 7, 1'b1);
			if (seen < 8) report_and_stop;
		end
	endtask

	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Sampling clock, held low while stopped
	initial begin
		cnt = 14'h0000;
		sc_run = 1;
		sample_clk = 0;
		forever begin
			#63;
			sample_clk = sc_run;
			#62;
			sample_clk = 0;
		end
	end
	always @(negedge sample_clk) cnt <= cnt + 14'h0001;

	// Successive words and their age against the running sample count
	always @(posedge oclk) if (chk_on) begin
		#2;
		if (seen > 0) begin
			check(w, prev + 14'h0001);
			check((cnt - w) > 14'h0008 && (cnt - w) < 14'h000d, 1'b1);
		end
		prev = w;
		seen = seen + 1;
	end

	initial begin
		rst = 1;
		{chk_on, use_pins, pin_pd, pin_buf, pin_diff, pin_twos, reg_stby} = 7'h00;
		{reg_pdn_obuf, reg_diff, reg_twos, reg_ext_ref, reg_coarse_gain} = 5'h00;
		{reg_current_double, dly_sel, reg_fine_gain, reg_drive_strength} = 9'h000;
		{reg_lvds_current, flip, seen, n_errors, n_checks} = 0;
		// Fine gain, drive, expected fine and drive, coarse ext double delay
		rows[0] = 20'h0_0000;
		rows[1] = 20'h0_f9fa;
		rows[2] = 20'h1_52a5;
		rows[3] = 20'h1_abaf;
		rows[4] = 20'h2_0406;
		rows[5] = 20'h2_fdf9;
		rows[6] = 20'h3_7ef3;
		rows[7] = 20'h3_d6ac;
		rows[8] = 20'h0_18a0;
		rows[9] = 20'h3_800f;
		repeat (16) @(negedge clk_sys);
		rst = 0;
		@(negedge clk_sys);
		check({coarse_gain_ff, fine_gain_ff, lvds_current_ff}, 6'h00);
		for (i = 0; i < 10; i = i + 1) begin
			{reg_fine_gain, reg_drive_strength} = rows[i][17:11];
			{reg_coarse_gain, reg_ext_ref, reg_current_double, dly_sel} = rows[i][3:0];
			reg_lvds_current = i[1:0];
			repeat (3) @(negedge clk_sys);
			check(cfg, rows[i][10:0]);
			check(lvds_current_ff, i[1:0]);
		end
		for (i = 0; i < 8; i = i + 1) begin
			use_pins = i[2];
			{pin_buf, pin_pd} = i[2] ? i[1:0] : ~i[1:0];
			{reg_pdn_obuf, reg_stby} = i[2] ? ~i[1:0] : i[1:0];
			repeat (6) @(negedge clk_sys);
			check(power_mode_ff, i[1:0]);
			check({ref_on_ff, core_on_ff}, {i[1:0] != 2'h3, !i[0]});
			if (i[1]) check(&sample_bit_oe_n, 1'b1);
		end
		use_pins = 0;
		{reg_pdn_obuf, reg_stby} = 2'h0;
		wait_valid(6260);
		stream;
		reg_pdn_obuf = 1;
		repeat (6) @(negedge clk_sys);
		reg_pdn_obuf = 0;
		wait_valid(28);
		{reg_diff, reg_twos, reg_pdn_obuf} = 3'h7;
		flip = 14'h2000;
		repeat (6) @(negedge clk_sys);
		reg_pdn_obuf = 0;
		wait_valid(65);
		// Drain words coded before the format change
		repeat (200) @(negedge clk_sys);
		stream;
		sc_run = 0;
		repeat (200) @(negedge clk_sys);
		check({clock_stopped_ff, data_valid_ff}, 2'h2);
		sc_run = 1;
		wait_valid(6300);
		report_and_stop;
	end
endmodule // conv_output_ctrl_tb

bind conv_output_ctrl conv_output_ctrl_chk i_chk (.clk_sys(clk_sys), .rst(rst),
	.use_pins(use_pins), .reg_stby(reg_stby), .reg_pdn_obuf(reg_pdn_obuf),
	.reg_coarse_gain(reg_coarse_gain), .reg_lvds_current(reg_lvds_current),
	.coarse_gain_ff(coarse_gain_ff), .fine_gain_ff(fine_gain_ff),
	.lvds_current_ff(lvds_current_ff), .power_mode_ff(power_mode_ff),
	.core_on_ff(core_on_ff), .ref_on_ff(ref_on_ff), .clock_stopped_ff(clock_stopped_ff),
	.data_valid_ff(data_valid_ff), .sample_bit_oe_n(sample_bit_oe_n),
	.pair_bit_oe_n(pair_bit_oe_n), .output_clock_oe_n(output_clock_oe_n));

/* File: bench/sample_receiver.sv */
// Receiving logic model that captures sample words
`timescale 1ns/1ns
module sample_receiver (
	input  wire        output_clock,
	input  wire        output_clock_true,
	input  wire [13:0] sample_pins,
	input  wire [6:0]  pair_pins,
	output reg  [13:0] se_word,
	output reg  [13:0] ddr_word
);
	wire [13:0] se_d;
	wire [6:0]  pair_d;
	reg  [6:0]  even_ff;
	integer     i;
	// Lines as seen just before each edge
	assign #2 se_d = sample_pins;
	assign #2 pair_d = pair_pins;
	always @(posedge output_clock) se_word <= se_d;
	// Even bits stand at the rise, odd bits at the fall
	always @(posedge output_clock_true) even_ff <= pair_d;
	always @(negedge output_clock_true) begin
		for (i = 0; i < 7; i = i + 1) begin
			ddr_word[2 * i] <= even_ff[i];
			ddr_word[2 * i + 1] <= pair_d[i];
		end
	end
endmodule // sample_receiver

/* File: rtl/conv_ctrl_regs.vh */
// Constants for the converter control and output block
// Function
// [R1] One control bit selects internal or external reference.
// [R2] Trim gain field selects 0 to 6 dB in 1 dB steps.
// [R3] Separate bit enables fixed 3.5 dB gain step.
// [R4] After reset total gain is 0 dB.
// [R5] Four power modes, chosen by register bits or two parallel pins.
// [R6] Both low normal; pd only standby; buf only disable; both global.
// [R7] Global power down stops core, references, drivers; outputs high impedance.
// [R8] Valid data within 50 us after leaving global power down.
// [R9] Standby stops core only; valid data within 50 us after leaving.
// [R10] Output disable tristates; valid within 500 ns differential, 200 ns single.
// [R11] Clock slower than 1 MSPS enters stopped state; valid 50 us after resume.
// [R12] Sample of 14 bits with output clock; interface chosen by bit or pin.
// [R13] Single-ended mode drives each bit on own pin once per cycle.
// [R14] Receiver registers single-ended bits on output clock rising edge.
// [R15] Delay select bit shifts output clock for more receiver setup. Code only copies the bit to output_clock_delayed; output_clock is not shifted.
// [R16] Single-ended drive strength raisable via register field.
// [R17] Differential mode puts two bits per pair per cycle, 7 plus clock.
// [R18] Differential current default 3.5 mA, alternatives 2.5, 4.5, 1.75 mA.
// [R19] Doubling bit doubles differential current for data and clock.
// [R20] Even bits launch at output clock rise, odd bits at fall.
// [R21] Receiver captures both edges and rebuilds all 14 bits.
// [R22] Sample presented 9 sampling clock cycles after conversion start.
// [R23] Output coding two's complement or offset binary, by pin or bit.
`ifndef CONV_CTRL_REGS_VH
`define CONV_CTRL_REGS_VH
`define SAMPLE_W        14
`define PAIR_W          7
`define LATENCY_CYC     9
`define FIFO_DEPTH      16
`define SYS_CLK_MHZ     125
`define WAKE_SLOW_US    50
`define WAKE_DIFF_NS    500
`define WAKE_SE_NS      200
`define MIN_RATE_MSPS   1
`define WAKE_SLOW_CYC   ((`WAKE_SLOW_US * `SYS_CLK_MHZ))
`define WAKE_DIFF_CYC   ((`WAKE_DIFF_NS * `SYS_CLK_MHZ) / 1000)
`define WAKE_SE_CYC     ((`WAKE_SE_NS * `SYS_CLK_MHZ) / 1000)
`define STOP_CYC        ((1000 * `SYS_CLK_MHZ) / (`MIN_RATE_MSPS * 1000))
`define FINE_MAX        3'h6
`define FINE_RST        3'h0
`define DRIVE_DEFAULT   4'h0
`define DRIVE_STRONG    4'hf
`define DRIVE_MAX       4'ha
`define CUR_3P5         2'h0
`define CUR_2P5         2'h1
`define CUR_4P5         2'h2
`define CUR_1P75        2'h3
`define MODE_NORMAL     2'h0
`define MODE_STANDBY    2'h1
`define MODE_OBUF_OFF   2'h2
`define MODE_GLOBAL     2'h3
`endif

/* File: rtl/conv_output_ctrl.v */
// Converter control and sample output block
`timescale 1ns/1ns
`include "conv_ctrl_regs.vh"
module conv_output_ctrl (
	input  wire                    clk_sys,
	input  wire                    rst,
	input  wire                    sample_clk,
	input  wire [`SAMPLE_W-1:0]    core_data,
	input  wire                    use_pins,
	input  wire                    pin_pd,
	input  wire                    pin_buf,
	input  wire                    pin_diff,
	input  wire                    pin_twos,
	input  wire                    reg_stby,
	input  wire                    reg_pdn_obuf,
	input  wire                    reg_diff,
	input  wire                    reg_twos,
	input  wire                    reg_ext_ref,
	input  wire                    reg_coarse_gain,
	input  wire [2:0]              reg_fine_gain,
	input  wire                    output_clock_delay_select,
	input  wire [3:0]              reg_drive_strength,
	input  wire [1:0]              reg_lvds_current,
	input  wire                    reg_current_double,
	output reg                     ext_ref_sel_ff,
	output reg                     coarse_gain_ff,
	output reg  [2:0]              fine_gain_ff,
	output reg  [3:0]              drive_strength_ff,
	output reg  [1:0]              lvds_current_ff,
	output reg                     current_double_ff,
	output reg  [1:0]              power_mode_ff,
	output reg                     core_on_ff,
	output reg                     ref_on_ff,
	output reg                     clock_stopped_ff,
	output reg                     data_valid_ff,
	output reg  [`SAMPLE_W-1:0]    sample_bit,
	output reg  [`SAMPLE_W-1:0]    sample_bit_oe_n,
	output reg  [`PAIR_W-1:0]      pair_bit,
	output reg  [`PAIR_W-1:0]      pair_bit_oe_n,
	output reg                     output_clock,
	output reg                     output_clock_true,
	output reg                     output_clock_oe_n,
	output reg                     output_clock_delayed
);
	localparam ST_RUN  = 2'd0;
	localparam ST_WAKE = 2'd1;
	localparam ST_OFF  = 2'd2;

	localparam [15:0] SLOW_CYC = `WAKE_SLOW_CYC;
	localparam [15:0] DIFF_CYC = `WAKE_DIFF_CYC;
	localparam [15:0] SE_CYC   = `WAKE_SE_CYC;
	localparam [15:0] STOP_CYC = `STOP_CYC;

	// Combined power mode from pins or register bits
	function [1:0] mode_of;
		input pd;
		input bufoff;
		begin
			mode_of = {bufoff, pd};
		end
	endfunction

	reg                  sclk_s1_ff;
	reg                  sclk_s2_ff;
	reg                  sclk_s3_ff;
	reg [1:0]            pins_s1_ff;
	reg [1:0]            pins_s2_ff;
	reg [1:0]            cfg_s1_ff;
	reg [1:0]            cfg_s2_ff;
	reg [`SAMPLE_W-1:0]  pipe_ff [0:`LATENCY_CYC-1];
	reg [`LATENCY_CYC-1:0] pvld_ff;
	reg [15:0]           idle_cnt_ff;
	reg [15:0]           wake_cnt_ff;
	reg [1:0]            state_ff;
	reg [1:0]            prev_mode_ff;
	reg                  diff_ff;
	reg                  twos_ff;
	reg [`SAMPLE_W-1:0]  hold_ff;
	reg                  fall_pend_ff;
	reg                  dly_ff;
	reg [1:0]            nxt_state;
	reg [15:0]           nxt_wake;
	wire                 rise;
	wire                 fall;
	wire [1:0]           mode;
	wire                 diff_sel;
	wire                 twos_sel;
	wire [`SAMPLE_W-1:0] coded;
	wire                 fifo_ready;
	wire                 fifo_valid;
	wire [`SAMPLE_W-1:0] fifo_data;
	wire                 drivers_on;
	wire                 run_core;
	genvar               g;

	// Synchronisers for pins and sampling clock
	always @(posedge clk_sys) begin
		if (rst) begin
			sclk_s1_ff <= 1'b0;
			sclk_s2_ff <= 1'b0;
			sclk_s3_ff <= 1'b0;
			pins_s1_ff <= 2'b00;
			pins_s2_ff <= 2'b00;
			cfg_s1_ff  <= 2'b00;
			cfg_s2_ff  <= 2'b00;
		end else begin
			sclk_s1_ff <= sample_clk;
			sclk_s2_ff <= sclk_s1_ff;
			sclk_s3_ff <= sclk_s2_ff;
			pins_s1_ff <= {pin_buf, pin_pd};
			pins_s2_ff <= pins_s1_ff;
			cfg_s1_ff  <= {pin_twos, pin_diff};
			cfg_s2_ff  <= cfg_s1_ff;
		end
	end

	assign rise     = sclk_s2_ff & ~sclk_s3_ff;
	assign fall     = ~sclk_s2_ff & sclk_s3_ff;
	assign mode     = use_pins ? mode_of(pins_s2_ff[0], pins_s2_ff[1]) // see [R5]
		: mode_of(reg_stby, reg_pdn_obuf); // see [R6]
	assign diff_sel = use_pins ? cfg_s2_ff[0] : reg_diff; // see [R12]
	assign twos_sel = use_pins ? cfg_s2_ff[1] : reg_twos; // see [R23]
	assign coded    = twos_sel ? {~core_data[`SAMPLE_W-1], core_data[`SAMPLE_W-2:0]}
		: core_data;
	assign run_core = (mode == `MODE_NORMAL) || (mode == `MODE_OBUF_OFF);
	assign drivers_on = (mode == `MODE_NORMAL) || (mode == `MODE_STANDBY);

	// Configuration registers, gain 0 dB after reset
	always @(posedge clk_sys) begin
		if (rst) begin
			ext_ref_sel_ff    <= 1'b0;
			coarse_gain_ff    <= 1'b0; // see [R4]
			fine_gain_ff      <= `FINE_RST; // see [R4]
			drive_strength_ff <= `DRIVE_DEFAULT;
			lvds_current_ff   <= `CUR_3P5; // see [R18]
			current_double_ff <= 1'b0;
			diff_ff           <= 1'b0;
			twos_ff           <= 1'b0;
			dly_ff            <= 1'b0;
		end else begin
			ext_ref_sel_ff    <= reg_ext_ref; // see [R1]
			coarse_gain_ff    <= reg_coarse_gain; // see [R3]
			if (reg_fine_gain <= `FINE_MAX)
				fine_gain_ff <= reg_fine_gain; // see [R2]
			if (reg_drive_strength == `DRIVE_DEFAULT ||
				reg_drive_strength == `DRIVE_STRONG ||
				reg_drive_strength == `DRIVE_MAX)
				drive_strength_ff <= reg_drive_strength; // see [R16]
			lvds_current_ff   <= reg_lvds_current; // see [R18]
			current_double_ff <= reg_current_double; // see [R19]
			diff_ff           <= diff_sel;
			twos_ff           <= twos_sel;
			dly_ff            <= output_clock_delay_select;
		end
	end

	// Stopped clock detector
	always @(posedge clk_sys) begin
		if (rst) begin
			idle_cnt_ff      <= 16'h0000;
			clock_stopped_ff <= 1'b0;
		end else if (rise) begin
			idle_cnt_ff      <= 16'h0000;
			clock_stopped_ff <= 1'b0;
		end else if (idle_cnt_ff >= STOP_CYC) begin
			clock_stopped_ff <= 1'b1; // see [R11]
		end else begin
			idle_cnt_ff <= idle_cnt_ff + 16'h0001;
		end
	end

	// Wake-up sequencer
	always @* begin
		nxt_state = state_ff;
		nxt_wake  = wake_cnt_ff;
		case (state_ff)
		ST_RUN: begin
			if (mode != `MODE_NORMAL || clock_stopped_ff)
				nxt_state = ST_OFF;
		end
		ST_OFF: begin
			if (mode == `MODE_NORMAL && !clock_stopped_ff) begin
				nxt_state = ST_WAKE;
				if (prev_mode_ff == `MODE_OBUF_OFF)
					nxt_wake = diff_ff ? DIFF_CYC : SE_CYC; // see [R10]
				else
					nxt_wake = SLOW_CYC; // see [R8] [R9] [R11]
			end
		end
		ST_WAKE: begin
			if (mode != `MODE_NORMAL || clock_stopped_ff)
				nxt_state = ST_OFF;
			else if (wake_cnt_ff <= 16'h0001)
				nxt_state = ST_RUN;
			else
				nxt_wake = wake_cnt_ff - 16'h0001;
		end
		default: nxt_state = ST_OFF;
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			state_ff      <= ST_WAKE;
			wake_cnt_ff   <= SLOW_CYC;
			prev_mode_ff  <= `MODE_NORMAL;
			power_mode_ff <= `MODE_NORMAL;
			core_on_ff    <= 1'b0;
			ref_on_ff     <= 1'b0;
			data_valid_ff <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			wake_cnt_ff   <= nxt_wake;
			power_mode_ff <= mode;
			if (mode != `MODE_NORMAL)
				prev_mode_ff <= clock_stopped_ff ? `MODE_GLOBAL : mode;
			else if (clock_stopped_ff)
				prev_mode_ff <= `MODE_GLOBAL;
			core_on_ff    <= run_core & ~clock_stopped_ff; // see [R9]
			ref_on_ff     <= (mode != `MODE_GLOBAL); // see [R7]
			data_valid_ff <= (nxt_state == ST_RUN);
		end
	end

	// Nine-stage conversion latency
	always @(posedge clk_sys) begin
		if (rst)
			pvld_ff <= {`LATENCY_CYC{1'b0}};
		else if (rise)
			pvld_ff <= {pvld_ff[`LATENCY_CYC-2:0], core_on_ff}; // see [R22]
	end

	generate
		for (g = 0; g < `LATENCY_CYC; g = g + 1) begin : g_pipe
			always @(posedge clk_sys) begin
				if (rise)
					pipe_ff[g] <= (g == 0) ? coded : pipe_ff[(g == 0) ? 0 : g-1];
			end
		end
	endgenerate

	sample_fifo #(
		.WIDTH (`SAMPLE_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk       (clk_sys),
		.rst       (rst),
		.in_valid  (rise & pvld_ff[`LATENCY_CYC-1]),
		.in_ready  (fifo_ready),
		.in_data   (pipe_ff[`LATENCY_CYC-1]),
		.out_valid (fifo_valid),
		.out_ready (rise),
		.out_data  (fifo_data),
		.flush     (~core_on_ff)
	);

	// Output launch: single-ended each rise, differential even on rise, odd on fall
	always @(posedge clk_sys) begin
		if (rst) begin
			sample_bit           <= {`SAMPLE_W{1'b0}};
			pair_bit             <= {`PAIR_W{1'b0}};
			hold_ff              <= {`SAMPLE_W{1'b0}};
			fall_pend_ff         <= 1'b0;
			output_clock         <= 1'b0;
			output_clock_true    <= 1'b0;
			output_clock_delayed <= 1'b0;
		end else begin
			output_clock         <= sclk_s3_ff;
			output_clock_true    <= sclk_s3_ff;
			output_clock_delayed <= dly_ff; // see [R15]
			if (rise && fifo_valid && data_valid_ff) begin
				hold_ff      <= fifo_data;
				sample_bit   <= fifo_data; // see [R13]
				fall_pend_ff <= diff_ff;
				pair_bit     <= even_bits(fifo_data); // see [R17] [R20]
			end else if (fall && fall_pend_ff) begin
				fall_pend_ff <= 1'b0;
				pair_bit     <= odd_bits(hold_ff); // see [R20]
			end
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			sample_bit_oe_n   <= {`SAMPLE_W{1'b1}};
			pair_bit_oe_n     <= {`PAIR_W{1'b1}};
			output_clock_oe_n <= 1'b1;
		end else begin
			sample_bit_oe_n   <= {`SAMPLE_W{~(drivers_on & ~diff_ff)}}; // see [R7] [R10]
			pair_bit_oe_n     <= {`PAIR_W{~(drivers_on & diff_ff)}}; // see [R12]
			output_clock_oe_n <= ~drivers_on;
		end
	end

	function [`PAIR_W-1:0] even_bits;
		input [`SAMPLE_W-1:0] d;
		integer i;
		begin
			for (i = 0; i < `PAIR_W; i = i + 1)
				even_bits[i] = d[2*i];
		end
	endfunction

	function [`PAIR_W-1:0] odd_bits;
		input [`SAMPLE_W-1:0] d;
		integer i;
		begin
			for (i = 0; i < `PAIR_W; i = i + 1)
				odd_bits[i] = d[2*i+1];
		end
	endfunction
endmodule // conv_output_ctrl

/* File: rtl/sample_fifo.v */
// Parameterised valid/ready FIFO for sample words
`timescale 1ns/1ns
module sample_fifo #(
	parameter WIDTH = 14,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	input  wire             flush
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ff;
	reg [AW-1:0]    rd_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid = (cnt_ff != {(AW+1){1'b0}});
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid & in_ready & ~flush;
	assign pop       = out_valid & out_ready & ~flush;

	always @(posedge clk) begin
		if (push)
			mem_ff[wr_ff] <= in_data;
	end

	always @(posedge clk) begin
		if (rst | flush) begin
			wr_ff  <= {AW{1'b0}};
			rd_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ff <= wr_ff + 1'b1;
			if (pop)
				rd_ff <= rd_ff + 1'b1;
			if (push & ~pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop & ~push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // sample_fifo
